// ===== srff_pkg.sv
// constants and types shared by the receive frame format block
package srff_pkg;
  // register bus geometry
  localparam int          SRFF_AW            = 5;
  localparam logic [4:0]  SRFF_ADDR_RX_CTRL  = 5'h00;
  localparam logic [4:0]  SRFF_ADDR_TX_CTRL  = 5'h04;
  localparam logic [4:0]  SRFF_ADDR_LAST_RX  = 5'h08;
  localparam logic [4:0]  SRFF_ADDR_STATUS   = 5'h0C;
  localparam logic [1:0]  SRFF_RESP_OKAY     = 2'b00;
  localparam logic [1:0]  SRFF_RESP_SLVERR   = 2'b10;

  // frame control field positions, shared by receive and transmit
  localparam int          SRFF_DUAL_BIT      = 31;
  localparam int          SRFF_LEN2_LSB      = 24;
  localparam int          SRFF_SIZE2_LSB     = 21;
  localparam int          SRFF_EXP_LSB       = 19;
  localparam int          SRFF_IGN_BIT       = 18;
  localparam int          SRFF_DLY_LSB       = 16;
  localparam int          SRFF_LEN1_LSB      = 8;
  localparam int          SRFF_SIZE1_LSB     = 5;
  localparam int          SRFF_REV_BIT       = 4;

  // writable bits (15 and 3..0 reserved) and reset value
  localparam logic [31:0] SRFF_CTRL_WMASK    = 32'hFFFF_7FF0;
  localparam logic [31:0] SRFF_CTRL_RESET    = 32'h0000_0000;

  // expansion mode codes
  localparam logic [1:0]  SRFF_EXP_NONE      = 2'h0;
  localparam logic [1:0]  SRFF_EXP_LSB_FIRST = 2'h1;
  localparam logic [1:0]  SRFF_EXP_MU        = 2'h2;
  localparam logic [1:0]  SRFF_EXP_A         = 2'h3;

  // word size codes
  localparam logic [2:0]  SRFF_SIZE_8        = 3'h0;
  localparam logic [2:0]  SRFF_SIZE_32       = 3'h5;

  // receive link state
  typedef enum logic [1:0] {SRFF_IDLE, SRFF_DELAY, SRFF_SHIFT} srff_lstate_t;
endpackage : srff_pkg

// ===== srff_receiver.sv
// receive frame format block: register slave, link receiver and crossings
`timescale 1ns/1ps

module srff_receiver (
  input  logic                        aclk,          // bus clock
  input  logic                        aresetn,       // sync reset, low
  input  logic [srff_pkg::SRFF_AW-1:0] s_axi_awaddr, // write address
  input  logic                        s_axi_awvalid, // write address valid
  output logic                        s_axi_awready, // write address ready
  input  logic [31:0]                 s_axi_wdata,   // write data
  input  logic [3:0]                  s_axi_wstrb,   // byte enables
  input  logic                        s_axi_wvalid,  // write data valid
  output logic                        s_axi_wready,  // write data ready
  output logic [1:0]                  s_axi_bresp,   // write response
  output logic                        s_axi_bvalid,  // write response valid
  input  logic                        s_axi_bready,  // write response ready
  input  logic [srff_pkg::SRFF_AW-1:0] s_axi_araddr, // read address
  input  logic                        s_axi_arvalid, // read address valid
  output logic                        s_axi_arready, // read address ready
  output logic [31:0]                 s_axi_rdata,   // read data
  output logic [1:0]                  s_axi_rresp,   // read response
  output logic                        s_axi_rvalid,  // read data valid
  input  logic                        s_axi_rready,  // read data ready
  input  logic                        rx_clk,        // link bit clock
  input  logic                        rx_data,       // serial data in
  input  logic                        rx_sync,       // frame sync in
  output logic [31:0]                 rx_word,       // received word
  output logic                        rx_word_valid  // one-cycle word strobe
);
  import srff_pkg::*;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        aw_got;
    logic        w_got;
    logic [4:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [31:0] rx_ctrl;
    logic [31:0] tx_ctrl;
    logic [31:0] cfg_hold;
    logic        cfg_req;
    logic        ack_s1;
    logic        ack_s2;
    logic        wt_s1;
    logic        wt_s2;
    logic        wt_s3;
    logic [31:0] last_word;
    logic [15:0] word_total;
    logic [31:0] word_out;
    logic        word_valid;
  } srff_bus_st_t;

  typedef struct packed {
    logic [31:0]  cfg;
    logic         sync_q;
    logic         sync_prev;
    logic         data_q;
    srff_lstate_t state;
    logic [1:0]   dly;
    logic [5:0]   bit_cnt;
    logic [6:0]   word_cnt;
    logic         phase2;
    logic [31:0]  sh;
    logic [31:0]  word;
    logic         word_tog;
    logic         rq_s1;
    logic         rq_s2;
    logic         rq_s3;
    logic         ack;
  } srff_link_st_t;

  srff_bus_st_t  b;
  srff_bus_st_t  next_b;
  srff_link_st_t l;
  srff_link_st_t next_l;
  logic          lrst_s1;
  logic          lrst_n;

  // bits per word for a size code; reserved codes fall back to 32
  function automatic logic [5:0] srff_size_bits(input logic [2:0] code);
    case (code)
      3'h0:    srff_size_bits = 6'd8;
      3'h1:    srff_size_bits = 6'd12;
      3'h2:    srff_size_bits = 6'd16;
      3'h3:    srff_size_bits = 6'd20;
      3'h4:    srff_size_bits = 6'd24;
      default: srff_size_bits = 6'd32;
    endcase
  endfunction : srff_size_bits

  // mu-law byte to sign-extended 16-bit linear
  function automatic logic [31:0] srff_mulaw(input logic [7:0] code);
    logic [7:0]  u;
    logic [15:0] t;
    logic [15:0] r;
    u = ~code;
    t = ({9'h000, u[3:0], 3'b000} + 16'h0084) << u[6:4];
    r = u[7] ? 16'h0084 - t : t - 16'h0084;
    srff_mulaw = {{16{r[15]}}, r};
  endfunction : srff_mulaw

  // A-law byte to sign-extended 16-bit linear
  function automatic logic [31:0] srff_alaw(input logic [7:0] code);
    logic [7:0]  a;
    logic [15:0] t;
    logic [15:0] r;
    a = code ^ 8'h55;
    t = {8'h00, a[3:0], 4'h0};
    if (a[6:4] == 3'h0) begin
      t = t + 16'h0008;
    end else begin
      t = (t + 16'h0108) << (a[6:4] - 3'h1);
    end
    r = a[7] ? t : 16'h0000 - t;
    srff_alaw = {{16{r[15]}}, r};
  endfunction : srff_alaw

  // byte-lane merge of a bus write into a control register
  function automatic logic [31:0] srff_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    srff_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        srff_merge[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    srff_merge = srff_merge & SRFF_CTRL_WMASK;
  endfunction : srff_merge

  // link-side decode of the current word
  logic         sync_edge;
  logic         cfg_load;
  logic         start;
  logic         take;
  logic         push;
  logic         last_bit;
  logic         phase_now;
  logic [6:0]   wc_now;
  logic [5:0]   bc_now;
  logic [31:0]  sh_now;
  logic [2:0]   code_now;
  logic [5:0]   nbits;
  logic [1:0]   mode;
  logic         size8;
  logic         lsb_first;
  logic [31:0]  sh_next;
  logic [31:0]  raw;
  logic [31:0]  assembled;
  logic [1:0]   dly_field;

  // link domain next state
  always_comb begin
    dly_field = l.cfg[SRFF_DLY_LSB +: 2];
    sync_edge = l.sync_q & ~l.sync_prev;
    cfg_load  = l.rq_s2 != l.rq_s3;
    start     = sync_edge && !cfg_load
                && (l.state == SRFF_IDLE || !l.cfg[SRFF_IGN_BIT]);
    phase_now = start ? 1'b0 : l.phase2;
    wc_now    = start ? 7'd0 : l.word_cnt;
    bc_now    = start ? 6'd0 : l.bit_cnt;
    sh_now    = start ? 32'h0000_0000 : l.sh;
    // phase two size only counts in a dual-phase frame
    code_now  = phase_now ? l.cfg[SRFF_SIZE2_LSB +: 3]
                          : l.cfg[SRFF_SIZE1_LSB +: 3];
    nbits     = srff_size_bits(code_now);
    mode      = l.cfg[SRFF_EXP_LSB +: 2];
    size8     = code_now == SRFF_SIZE_8;
    lsb_first = (size8 && mode == SRFF_EXP_LSB_FIRST)
                || (l.cfg[SRFF_REV_BIT] && code_now == SRFF_SIZE_32);
    take      = start ? (dly_field == 2'h0)
                      : (l.state == SRFF_SHIFT
                         || (l.state == SRFF_DELAY && l.dly == 2'h0));
    last_bit  = bc_now == nbits - 6'd1;
    push      = take && last_bit;
    sh_next   = lsb_first ? {l.data_q, sh_now[31:1]} : {sh_now[30:0], l.data_q};
    // right-justify the word whichever end it came in from
    raw       = lsb_first ? sh_next >> (6'd32 - nbits)
                          : sh_next & (32'hFFFF_FFFF >> (6'd32 - nbits));
    // expansion only applies to 8-bit words
    if (size8 && mode == SRFF_EXP_MU) begin
      assembled = srff_mulaw(raw[7:0]);
    end else if (size8 && mode == SRFF_EXP_A) begin
      assembled = srff_alaw(raw[7:0]);
    end else begin
      assembled = raw;
    end

    next_l           = l;
    next_l.sync_q    = rx_sync;
    next_l.sync_prev = l.sync_q;
    next_l.data_q    = rx_data;
    next_l.rq_s1     = b.cfg_req;
    next_l.rq_s2     = l.rq_s1;
    next_l.rq_s3     = l.rq_s2;
    next_l.ack       = l.rq_s2;
    if (cfg_load) begin
      // new settings abort any frame in flight rather than mix formats
      next_l.cfg      = b.cfg_hold;
      next_l.state    = SRFF_IDLE;
      next_l.phase2   = 1'b0;
      next_l.word_cnt = 7'd0;
      next_l.bit_cnt  = 6'd0;
    end else begin
      unique case (l.state)
        SRFF_IDLE: begin
          next_l.state = SRFF_IDLE;
        end
        SRFF_DELAY: begin
          if (l.dly != 2'h0) begin
            next_l.dly = l.dly - 2'h1;
          end else begin
            next_l.state = SRFF_SHIFT;
          end
        end
        SRFF_SHIFT: begin
          next_l.state = SRFF_SHIFT;
        end
      endcase
      next_l.phase2   = phase_now;
      next_l.word_cnt = wc_now;
      next_l.bit_cnt  = bc_now;
      next_l.sh       = sh_now;
      if (start) begin
        next_l.state = (dly_field == 2'h0) ? SRFF_SHIFT : SRFF_DELAY;
        next_l.dly   = dly_field - 2'h1;
      end
      if (take) begin
        next_l.sh      = sh_next;
        next_l.bit_cnt = bc_now + 6'd1;
        if (last_bit) begin
          next_l.word     = assembled;
          next_l.word_tog = ~l.word_tog;
          next_l.bit_cnt  = 6'd0;
          next_l.sh       = 32'h0000_0000;
          next_l.word_cnt = wc_now + 7'd1;
          if (!phase_now && wc_now == l.cfg[SRFF_LEN1_LSB +: 7]) begin
            next_l.word_cnt = 7'd0;
            if (l.cfg[SRFF_DUAL_BIT]) begin
              next_l.phase2 = 1'b1;
            end else begin
              next_l.state = SRFF_IDLE;
            end
          end else if (phase_now && wc_now == l.cfg[SRFF_LEN2_LSB +: 7]) begin
            next_l.word_cnt = 7'd0;
            next_l.phase2   = 1'b0;
            next_l.state    = SRFF_IDLE;
          end
        end
      end
    end
  end

  // reset release into the link domain; these two stay unreset
  always_ff @(posedge rx_clk) begin
    lrst_s1 <= aresetn;
    lrst_n  <= lrst_s1;
  end

  // link domain state
  always_ff @(posedge rx_clk) begin
    if (!lrst_n) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  logic        wr_fire;
  logic        rd_fire;
  logic        word_evt;

  // bus domain next state: register slave and crossings
  always_comb begin
    next_b        = b;
    next_b.ack_s1 = l.ack;
    next_b.ack_s2 = b.ack_s1;
    next_b.wt_s1  = l.word_tog;
    next_b.wt_s2  = b.wt_s1;
    next_b.wt_s3  = b.wt_s2;
    // word is held by the link for many bus cycles past its toggle
    word_evt          = b.wt_s2 != b.wt_s3;
    next_b.word_valid = word_evt;
    if (word_evt) begin
      next_b.word_out   = l.word;
      next_b.last_word  = l.word;
      next_b.word_total = b.word_total + 16'h0001;
    end
    // one settings transfer at a time; hold stays put until acknowledged
    if (b.cfg_req == b.ack_s2 && b.cfg_hold != b.rx_ctrl) begin
      next_b.cfg_hold = b.rx_ctrl;
      next_b.cfg_req  = ~b.cfg_req;
    end
    // write address and data in either order
    if (s_axi_awvalid && b.awready) begin
      next_b.aw_got = 1'b1;
      next_b.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && b.wready) begin
      next_b.w_got = 1'b1;
      next_b.wdata = s_axi_wdata;
      next_b.wstrb = s_axi_wstrb;
    end
    if (b.bvalid && s_axi_bready) begin
      next_b.bvalid = 1'b0;
    end
    wr_fire = next_b.aw_got && next_b.w_got && !b.bvalid;
    if (wr_fire) begin
      next_b.aw_got = 1'b0;
      next_b.w_got  = 1'b0;
      next_b.bvalid = 1'b1;
      next_b.bresp  = SRFF_RESP_OKAY;
      case (next_b.awaddr)
        SRFF_ADDR_RX_CTRL: next_b.rx_ctrl = srff_merge(b.rx_ctrl, next_b.wdata,
                                                       next_b.wstrb);
        SRFF_ADDR_TX_CTRL: next_b.tx_ctrl = srff_merge(b.tx_ctrl, next_b.wdata,
                                                       next_b.wstrb);
        SRFF_ADDR_LAST_RX, SRFF_ADDR_STATUS: next_b.bresp = SRFF_RESP_OKAY;
        default:           next_b.bresp = SRFF_RESP_SLVERR;
      endcase
    end
    next_b.awready = !next_b.aw_got && !next_b.bvalid;
    next_b.wready  = !next_b.w_got && !next_b.bvalid;
    // read channel, one outstanding
    if (b.rvalid && s_axi_rready) begin
      next_b.rvalid = 1'b0;
    end
    rd_fire = s_axi_arvalid && b.arready;
    if (rd_fire) begin
      next_b.rvalid = 1'b1;
      next_b.rresp  = SRFF_RESP_OKAY;
      case (s_axi_araddr)
        SRFF_ADDR_RX_CTRL: next_b.rdata = b.rx_ctrl;
        SRFF_ADDR_TX_CTRL: next_b.rdata = b.tx_ctrl;
        SRFF_ADDR_LAST_RX: next_b.rdata = b.last_word;
        SRFF_ADDR_STATUS:  next_b.rdata = {16'h0000, b.word_total};
        default: begin
          next_b.rdata = 32'h0000_0000;
          next_b.rresp = SRFF_RESP_SLVERR;
        end
      endcase
    end
    next_b.arready = !next_b.rvalid;
  end

  // bus domain state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      b         <= '0;
      b.rx_ctrl <= SRFF_CTRL_RESET;
      b.tx_ctrl <= SRFF_CTRL_RESET;
    end else begin
      b <= next_b;
    end
  end

  // outputs straight from state
  assign s_axi_awready = b.awready;
  assign s_axi_wready  = b.wready;
  assign s_axi_bresp   = b.bresp;
  assign s_axi_bvalid  = b.bvalid;
  assign s_axi_arready = b.arready;
  assign s_axi_rdata   = b.rdata;
  assign s_axi_rresp   = b.rresp;
  assign s_axi_rvalid  = b.rvalid;
  assign rx_word       = b.word_out;
  assign rx_word_valid = b.word_valid;

  // link checks
  AST_PHASE_TWO_END: assert property (@(posedge rx_clk) disable iff (!lrst_n)
    (push && !start && !cfg_load && l.phase2 && l.word_cnt == l.cfg[SRFF_LEN2_LSB +: 7])
    |=> (l.state == SRFF_IDLE && !l.phase2 && l.word_cnt == 7'd0))
    else $error("phase two did not end after its word count");
  AST_PHASE_ONE_END: assert property (@(posedge rx_clk) disable iff (!lrst_n)
    (push && !start && !cfg_load && !l.phase2 && l.cfg[SRFF_DUAL_BIT]
     && l.word_cnt == l.cfg[SRFF_LEN1_LSB +: 7]) |=> (l.phase2 && l.word_cnt == 7'd0))
    else $error("phase one did not hand over to phase two");
  AST_SIZE_TWO: assert property (@(posedge rx_clk) disable iff (!lrst_n)
    (take && !start && !cfg_load && l.phase2 && l.cfg[SRFF_SIZE2_LSB +: 3] == 3'h1)
    |-> (push == (l.bit_cnt == 6'd11)))
    else $error("phase two 12-bit word closed at wrong bit");
  AST_SIZE_ONE: assert property (@(posedge rx_clk) disable iff (!lrst_n)
    (take && !start && !cfg_load && !l.phase2 && l.cfg[SRFF_SIZE1_LSB +: 3] == 3'h4)
    |-> (push == (l.bit_cnt == 6'd23)))
    else $error("phase one 24-bit word closed at wrong bit");
  AST_EXPAND_LAW: assert property (@(posedge rx_clk) disable iff (!lrst_n)
    (push && !cfg_load && size8 && mode[1])
    |=> (l.word[31:16] == {16{l.word[15]}} && l.word[1:0] == 2'h0))
    else $error("expanded word is not a sign-extended linear sample");
  AST_EXPAND_NONE: assert property (@(posedge rx_clk) disable iff (!lrst_n)
    (push && !cfg_load && size8 && mode == SRFF_EXP_NONE)
    |=> (l.word[31:8] == 24'h00_0000 && l.word[0] == $past(l.data_q)))
    else $error("plain 8-bit word altered");
  AST_LSB_FIRST: assert property (@(posedge rx_clk) disable iff (!lrst_n)
    (push && !cfg_load && size8 && mode == SRFF_EXP_LSB_FIRST)
    |=> (l.word[31:8] == 24'h00_0000 && l.word[7] == $past(l.data_q)))
    else $error("lsb-first byte assembled in wrong order");
  AST_WIDE_NO_EXPAND: assert property (@(posedge rx_clk) disable iff (!lrst_n)
    (push && !cfg_load && !size8 && mode != SRFF_EXP_NONE && !l.cfg[SRFF_REV_BIT])
    |=> (l.word[0] == $past(l.data_q)))
    else $error("expansion applied to a wide word");
  AST_SYNC_RESTART: assert property (@(posedge rx_clk) disable iff (!lrst_n)
    (sync_edge && !cfg_load && l.state != SRFF_IDLE && !l.cfg[SRFF_IGN_BIT]
     && l.cfg[SRFF_DLY_LSB +: 2] == 2'h0)
    |=> (l.bit_cnt == 6'd1 && l.word_cnt == 7'd0 && !l.phase2))
    else $error("frame sync did not restart the transfer");
  AST_SYNC_IGNORE: assert property (@(posedge rx_clk) disable iff (!lrst_n)
    (sync_edge && !cfg_load && l.state == SRFF_SHIFT && l.cfg[SRFF_IGN_BIT] && !push)
    |=> (l.bit_cnt == $past(l.bit_cnt) + 6'd1))
    else $error("frame sync disturbed a transfer while ignored");
  AST_DELAY_TWO: assert property (@(posedge rx_clk) disable iff (!lrst_n)
    (start && l.cfg[SRFF_DLY_LSB +: 2] == 2'h2) |-> !take ##1 !take ##1 take)
    else $error("two-bit delay not honoured");
  AST_DELAY_ONE: assert property (@(posedge rx_clk) disable iff (!lrst_n)
    (start && l.cfg[SRFF_DLY_LSB +: 2] == 2'h1) |-> !take ##1 take)
    else $error("one-bit delay not honoured");
  AST_REVERSE: assert property (@(posedge rx_clk) disable iff (!lrst_n)
    (push && !cfg_load && l.cfg[SRFF_REV_BIT] && code_now == SRFF_SIZE_32)
    |=> (l.word[31] == $past(l.data_q)))
    else $error("reversed 32-bit word assembled msb first");
  AST_DUAL_ONLY: assert property (@(posedge rx_clk) disable iff (!lrst_n)
    l.phase2 |-> l.cfg[SRFF_DUAL_BIT])
    else $error("phase two entered in a single-phase frame");
  // bus checks
  AST_RESERVED_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_fire && s_axi_araddr == SRFF_ADDR_RX_CTRL)
    |=> (s_axi_rdata[15] == 1'b0 && s_axi_rdata[3:0] == 4'h0))
    else $error("reserved receive control bits read nonzero");
  AST_TX_LAYOUT: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && next_b.awaddr == SRFF_ADDR_TX_CTRL && next_b.wstrb == 4'hF)
    |=> (b.tx_ctrl == ($past(next_b.wdata) & SRFF_CTRL_WMASK)))
    else $error("transmit control write not stored with its layout");
endmodule : srff_receiver

// ===== srff_codec_model.sv
// behavioural serial source standing in for the far-side codec
`timescale 1ns/1ps
module srff_codec_model (
  input  wire logic rx_clk,  // link bit clock
  output logic      rx_data, // serial data to the receiver
  output logic      rx_sync  // frame sync to the receiver
);
  logic idle_bit = 1'h0;
  logic busy     = 1'h0;
  logic drv      = 1'h0;
  initial rx_sync = 1'h0;
  // released line toggles so a stale bit never passes for data
  always @(negedge rx_clk) idle_bit <= ~idle_bit;
  assign rx_data = busy ? drv : idle_bit;
  // streams bits from 63 downward, cyclic; syncs in slot 0 and slot again
  task send(input logic [63:0] bits, input int n, dly, again);
    for (int t = 0; t < n + dly; t++) begin
      @(negedge rx_clk);
      busy    <= 1'h1;
      rx_sync <= (t == 0 || t == again);
      drv     <= (t >= dly) ? bits[63 - ((t - dly) % 64)] : ~idle_bit;
    end
    @(negedge rx_clk);
    busy    <= 1'h0;
    rx_sync <= 1'h0;
  endtask : send
endmodule : srff_codec_model

// ===== serial_receive_frame_format_bench.sv
// self-checking bench for the receive frame format block
`timescale 1ns/1ps
module serial_receive_frame_format_bench;
  import srff_pkg::*;
  localparam logic [63:0] P = 64'h1E5A_C396_0B6D_F247;
  logic        aclk = '0, aresetn = '0, rx_clk = '0;
  logic [4:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rx_word, lastw, d, e;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        rx_data, rx_sync, rx_word_valid;
  int          err_total = 0, checked = 0, wc = 0;
  srff_receiver dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rx_clk, .rx_data, .rx_sync, .rx_word, .rx_word_valid);
  srff_codec_model far_u (.rx_clk, .rx_data, .rx_sync);
  // clocks; link clock offset so the two never line up
  initial forever #20 aclk = ~aclk;
  initial begin
    #13;
    forever #80 rx_clk = ~rx_clk;
  end
  // word strobes counted here, so no wait hangs on a lost pulse
  always @(posedge aclk) if (rx_word_valid === 1'h1) begin
    wc    <= wc + 1;
    lastw <= rx_word;
  end
  task cmp(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task close_out;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  task wr(input logic [4:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  // control word from fields, top bit first
  function automatic logic [31:0] ctl(int du, l2, s2, ex, ig, dl, l1, s1, rv);
    return {1'(du), 7'(l2), 3'(s2), 2'(ex), 1'(ig), 2'(dl), 1'h0, 7'(l1), 3'(s1), 1'(rv), 4'h0};
  endfunction : ctl
  // program, let settings cross, send one frame, judge count and last word
  task run(input logic [31:0] c, input logic [63:0] b, input int n, dl, ag,
           input logic [31:0] x, input int cnt);
    int c0;
    wr(SRFF_ADDR_RX_CTRL, c, rs);
    repeat (4) @(posedge rx_clk);
    c0 = wc;
    far_u.send(b, n, dl, ag);
    repeat (2) @(posedge rx_clk);
    repeat (8) @(posedge aclk);
    cmp(32'(wc - c0), 32'(cnt));
    cmp(lastw, x);
  endtask : run
  task t_regs;
    rd(SRFF_ADDR_RX_CTRL, d, rs);
    cmp(d, 32'h0000_0000);
    rd(SRFF_ADDR_TX_CTRL, d, rs);
    cmp(d, 32'h0000_0000);
    wr(SRFF_ADDR_RX_CTRL, 32'hFFFF_FFFF, rs);
    cmp(32'(rs), 32'(SRFF_RESP_OKAY));
    rd(SRFF_ADDR_RX_CTRL, d, rs);
    cmp(d, 32'hFFFF_7FF0);
    cmp(32'(rs), 32'(SRFF_RESP_OKAY));
    wr(SRFF_ADDR_TX_CTRL, 32'hFFFF_FFFF, rs);
    rd(SRFF_ADDR_TX_CTRL, d, rs);
    cmp(d, 32'hFFFF_7FF0);
    // one byte lane only; the other lanes keep their contents
    s_axi_wstrb <= 4'h2;
    wr(SRFF_ADDR_TX_CTRL, 32'h0000_0000, rs);
    s_axi_wstrb <= 4'hF;
    rd(SRFF_ADDR_TX_CTRL, d, rs);
    cmp(d, 32'hFFFF_00F0);
    // unmapped place refuses both ways
    wr(5'h10, 32'hFFFF_FFFF, rs);
    cmp(32'(rs), 32'(SRFF_RESP_SLVERR));
    rd(5'h10, d, rs);
    cmp(32'(rs), 32'(SRFF_RESP_SLVERR));
  endtask : t_regs
  task t_sizes;
    int w;
    for (int s = 0; s < 6; s++) begin
      w = (s == 5) ? 32 : 8 + 4 * s;
      run(ctl(0, 0, 0, 0, 0, s % 3, 0, s, 0), P, w, s % 3, -1, 32'(P >> (64 - w)), 1);
      run(ctl(1, 0, s, 0, 0, s % 3, 0, 0, 0), P, 8 + w, s % 3, -1,
          32'((P << 8) >> (64 - w)), 2);
    end
  endtask : t_sizes
  task t_modes;
    e = {<<{P[63:32]}};
    run(ctl(0, 0, 0, 1, 0, 1, 0, 0, 0), P, 8, 1, -1, 32'h0000_0078, 1);
    run(ctl(0, 0, 0, 0, 0, 1, 0, 5, 1), P, 32, 1, -1, e, 1);
    run(ctl(0, 0, 0, 2, 0, 1, 0, 0, 0), {8'hFF, 56'h0}, 8, 1, -1, 32'h0000_0000, 1);
    run(ctl(0, 0, 0, 3, 0, 1, 0, 0, 0), {8'hD5, 56'h0}, 8, 1, -1, 32'h0000_0008, 1);
    run(ctl(0, 0, 0, 2, 0, 1, 0, 2, 0), P, 16, 1, -1, 32'h0000_1E5A, 1);
  endtask : t_modes
  task t_sync;
    run(ctl(0, 0, 0, 0, 0, 0, 0, 0, 0), P, 12, 0, 4, 32'(P[59:52]), 1);
    run(ctl(0, 0, 0, 0, 1, 0, 0, 0, 0), P, 12, 0, 4, 32'(P[63:56]), 1);
  endtask : t_sync
  task t_counts;
    run(ctl(0, 5, 0, 0, 0, 1, 2, 0, 0), P, 40, 1, -1, 32'(P[47:40]), 3);
    run(ctl(1, 2, 0, 0, 0, 1, 1, 0, 0), P, 56, 1, -1, 32'(P[31:24]), 5);
    run(ctl(0, 0, 0, 0, 0, 1, 127, 0, 0), P, 1040, 1, -1, 32'(P[7:0]), 128);
    rd(SRFF_ADDR_STATUS, d, rs);
    cmp(32'(d[15:0]), 32'(wc[15:0]));
    rd(SRFF_ADDR_LAST_RX, d, rs);
    cmp(d, 32'(P[7:0]));
  endtask : t_counts
  // whole run far exceeds any expected span if it gets here
  initial begin
    #2_000_000;
    err_total++;
    close_out;
  end
  initial begin
    repeat (8) @(posedge aclk);
    repeat (3) @(posedge rx_clk);
    @(posedge aclk);
    aresetn <= 1'h1;
    t_regs;
    t_sizes;
    t_modes;
    t_sync;
    t_counts;
    close_out;
  end
endmodule : serial_receive_frame_format_bench
